// File: rtl/ctrl_link_if.sv
`timescale 1ns/1ps
interface ctrl_link_if;

  // ----------------------------------------------------------------
  // Link wires
  // ----------------------------------------------------------------
  logic ctrl_serial_clock_pin;
  logic ctrl_serial_data_pin;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;

  // Open-drain wired-AND; an idle line is held high by the pull-up
  assign ctrl_serial_data_pin = !((sda_m_oe && !sda_m_o) ||
                                  (sda_s_oe && !sda_s_o));

  modport device (
    input  ctrl_serial_clock_pin,
    input  ctrl_serial_data_pin,
    output sda_s_o,
    output sda_s_oe
  );

  modport master (
    output ctrl_serial_clock_pin,
    output sda_m_o,
    output sda_m_oe,
    input  ctrl_serial_data_pin
  );

endinterface : ctrl_link_if

// File: rtl/i2c_regacc_device.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-wire register access slave
// ----------------------------------------------------------------
// Contract
// - Logic one is sent by releasing data line
// - Data fall while clock high starts transfer
// - Shift in eight identifier bits, MSB first
// - Identifier LSB: one reads, zero writes
// - Matching identifier is acknowledged with data low; a read identifier only after an address write in the same transfer
// - Mismatch or wrong direction: no ack, idle
// - Data rise while clock high stops transfer
// - Complete sequence returns device to idle
// - Unexpected data change with clock high aborts
// - Below boundary: 32-bit address, 16-bit words
// - At boundary and above: 32-bit words
// - Address increments after every whole word
// - Word every two or four data bytes
// - Single and multiple reads and writes supported
// - Ack holds data low, nack leaves high
// - Host waits for boot before writing; the host here starts on cmd_valid in H_IDLE with no boot wait
module i2c_regacc_device (
  // Link-domain clock and reset
  input  wire logic                              link_clk,
  input  wire logic                              srst,
  // Two-wire link
  ctrl_link_if.device                            link,
  // Register access port
  output logic [i2c_regacc_pkg::ADDR_W-1:0]      reg_addr,
  output logic [i2c_regacc_pkg::DATA_W-1:0]      reg_wdata,
  output logic                                   reg_wr,
  output logic                                   reg_rd,
  input  wire logic [i2c_regacc_pkg::DATA_W-1:0] reg_rdata
);
  import i2c_regacc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ID    = 3'h1,
    ST_ADDR  = 3'h3,
    ST_WDATA = 3'h2,
    ST_RDATA = 3'h6
  } dev_state_e;

  dev_state_e          state_q;
  logic [1:0]          scl_sync_q;
  logic [1:0]          sda_sync_q;
  logic                scl_q;
  logic                sda_q;
  logic [3:0]          cnt_q;
  logic [2:0]          byte_q;
  logic [BYTE_W-1:0]   sh_q;
  logic                ack_q;
  logic                drive_q;
  logic                have_addr_q;
  logic                load_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [DATA_W-1:0]   wd_q;
  logic [DATA_W-1:0]   tx_q;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  logic                id_match;
  logic                word_end;
  logic                byte_done;
  logic                rd_first;
  logic                wr_fire;
  logic                rd_next;
  logic [DATA_W-1:0]   wd_d;

  // ----------------------------------------------------------------
  // Pin synchronisers and line events
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (srst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], link.ctrl_serial_clock_pin};
      sda_sync_q <= {sda_sync_q[0], link.ctrl_serial_data_pin};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  assign scl_rise  = scl_sync_q[1] && !scl_q;
  assign scl_fall  = !scl_sync_q[1] && scl_q;
  // Any data edge while the clock is high is a start or a stop
  assign start_det = scl_sync_q[1] && scl_q && sda_q &&
                     !sda_sync_q[1];
  assign stop_det  = scl_sync_q[1] && scl_q && !sda_q &&
                     sda_sync_q[1];
  assign id_match  = sh_q[BYTE_W-1:1] == DEV_ADDR;
  assign word_end  = byte_q == word_bytes(addr_q) - 3'h1;
  assign wd_d      = {wd_q[DATA_W-BYTE_W-1:0], sh_q};
  assign byte_done = scl_fall && !ack_q && cnt_q == BIT_ACK &&
                     state_q != ST_RDATA && state_q != ST_IDLE;
  // A read is only honoured once an address has been written
  assign rd_first  = byte_done && state_q == ST_ID && id_match &&
                     sh_q[0] == RW_READ && have_addr_q;
  assign wr_fire   = byte_done && state_q == ST_WDATA && word_end;
  assign rd_next   = scl_rise && state_q == ST_RDATA && !ack_q &&
                     cnt_q == BIT_ACK && !sda_sync_q[1] && word_end;

  assign link.sda_s_o  = 1'b0;
  assign link.sda_s_oe = drive_q;

  // ----------------------------------------------------------------
  // Protocol state machine
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (srst) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 4'h0;
      byte_q      <= 3'h0;
      sh_q        <= '0;
      ack_q       <= 1'b0;
      drive_q     <= 1'b0;
      have_addr_q <= 1'b0;
      addr_q      <= '0;
      wd_q        <= '0;
    end else if (start_det) begin
      state_q <= ST_ID;
      cnt_q   <= 4'h0;
      ack_q   <= 1'b0;
      drive_q <= 1'b0;
    end else if (stop_det) begin
      state_q     <= ST_IDLE;
      ack_q       <= 1'b0;
      drive_q     <= 1'b0;
      have_addr_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (ack_q && scl_fall) begin
        ack_q   <= 1'b0;
        cnt_q   <= 4'h0;
        drive_q <= state_q == ST_RDATA && !tx_q[DATA_W-1];
      end else if (state_q == ST_RDATA && !ack_q) begin
        // Own acknowledge clock must not count as a master response
        if (scl_rise && cnt_q != BIT_ACK) begin
          cnt_q <= cnt_q + 4'h1;
        end else if (scl_rise) begin
          cnt_q <= 4'h0;
          if (sda_sync_q[1]) begin
            state_q <= ST_IDLE;
          end else begin
            byte_q <= word_end ? 3'h0 : byte_q + 3'h1;
            if (word_end) begin
              addr_q <= addr_q + 1'b1;
            end
          end
        end else if (scl_fall) begin
          // Release during the master's acknowledge slot
          drive_q <= cnt_q != BIT_ACK && !tx_q[DATA_W-1];
        end
      end else if (scl_rise && cnt_q != BIT_ACK) begin
        sh_q  <= {sh_q[BYTE_W-2:0], sda_sync_q[1]};
        cnt_q <= cnt_q + 4'h1;
      end else if (byte_done) begin
        case (state_q)
          ST_ID: begin
            if (id_match && sh_q[0] == RW_WRITE) begin
              state_q     <= ST_ADDR;
              byte_q      <= 3'h0;
              have_addr_q <= 1'b0;
              ack_q       <= 1'b1;
              drive_q     <= 1'b1;
            end else if (rd_first) begin
              state_q <= ST_RDATA;
              byte_q  <= 3'h0;
              ack_q   <= 1'b1;
              drive_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
          ST_ADDR: begin
            addr_q  <= {addr_q[ADDR_W-BYTE_W-1:0], sh_q};
            byte_q  <= byte_q + 3'h1;
            ack_q   <= 1'b1;
            drive_q <= 1'b1;
            if (byte_q == ADDR_BYTES - 3'h1) begin
              state_q     <= ST_WDATA;
              byte_q      <= 3'h0;
              have_addr_q <= 1'b1;
            end
          end
          default: begin
            wd_q    <= wd_d;
            byte_q  <= word_end ? 3'h0 : byte_q + 3'h1;
            ack_q   <= 1'b1;
            drive_q <= 1'b1;
            if (word_end) begin
              addr_q <= addr_q + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register access strobes and read data
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (srst) begin
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      load_q    <= 1'b0;
      reg_addr  <= '0;
      reg_wdata <= '0;
    end else begin
      reg_wr <= wr_fire;
      reg_rd <= rd_first || rd_next;
      load_q <= reg_rd;
      if (wr_fire) begin
        reg_addr  <= addr_q;
        reg_wdata <= is_wide(addr_q) ? wd_d :
          {{(DATA_W-NARROW_W){1'b0}}, wd_d[NARROW_W-1:0]};
      end else if (rd_first) begin
        reg_addr <= addr_q;
      end else if (rd_next) begin
        reg_addr <= addr_q + 1'b1;
      end
    end
  end

  // Narrow words are parked at the top so the MSB leaves first
  always_ff @(posedge link_clk) begin
    if (srst) begin
      tx_q <= '0;
    end else if (load_q) begin
      tx_q <= is_wide(addr_q) ? reg_rdata :
        {reg_rdata[NARROW_W-1:0], {(DATA_W-NARROW_W){1'b0}}};
    end else if (scl_rise && state_q == ST_RDATA && !ack_q &&
                 cnt_q != BIT_ACK) begin
      tx_q <= {tx_q[DATA_W-2:0], 1'b0};
    end
  end

endmodule : i2c_regacc_device

// File: rtl/i2c_regacc_host.sv
`timescale 1ns/1ps
module i2c_regacc_host #(
  parameter int SCL_QTR = 25,
  parameter int WORDS_W = 8
) (
  // System clock and reset
  input  wire logic                              clk,
  input  wire logic                              srst,
  // Two-wire link
  ctrl_link_if.master                            link,
  // Command port
  input  wire logic                              cmd_valid,
  output logic                                   cmd_ready,
  input  wire logic                              cmd_read,
  input  wire logic [i2c_regacc_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [WORDS_W-1:0]                cmd_words,
  // Write data
  input  wire logic [i2c_regacc_pkg::DATA_W-1:0] wr_data,
  output logic                                   wr_take,
  // Read data and completion
  output logic [i2c_regacc_pkg::DATA_W-1:0]      rd_data,
  output logic                                   rd_valid,
  output logic                                   done,
  output logic                                   nack
);
  import i2c_regacc_pkg::*;

  localparam int           QW       = $clog2(SCL_QTR);
  localparam logic [QW-1:0] QTR_LAST = QW'(SCL_QTR - 1);
  localparam logic [WORDS_W-1:0] WORD_ONE = WORDS_W'(1);

  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_BYTE  = 2'h3,
    H_STOP  = 2'h2
  } host_state_e;

  typedef enum logic [2:0] {
    PH_IDW  = 3'h0,
    PH_ADDR = 3'h1,
    PH_WR   = 3'h3,
    PH_IDR  = 3'h2,
    PH_RD   = 3'h6
  } phase_e;

  host_state_e         state_q;
  phase_e              phase_q;
  logic [QW-1:0]       qcnt_q;
  logic [1:0]          q_q;
  logic [3:0]          bit_q;
  logic [2:0]          byte_q;
  logic [WORDS_W-1:0]  words_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [DATA_W-1:0]   xs_q;
  logic [1:0]          sda_sync_q;
  logic                read_q;
  logic                err_q;
  logic                scl_q;
  logic                drive_q;
  logic                tick;
  logic                last_byte;
  logic                last_word;
  logic [DATA_W-1:0]   wr_aligned;

  function automatic logic [DATA_W-1:0] id_word(input logic rw);
    return {DEV_ADDR, rw, {(DATA_W-BYTE_W){1'b0}}};
  endfunction : id_word

  // Narrow words leave the top of the shifter so they go out first
  function automatic logic [DATA_W-1:0] align_wr(
    input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d
  );
    return is_wide(a) ? d : {d[NARROW_W-1:0], {(DATA_W-NARROW_W){1'b0}}};
  endfunction : align_wr

  assign tick       = qcnt_q == QTR_LAST;
  assign last_byte  = byte_q == word_bytes(addr_q) - 3'h1;
  assign last_word  = words_q == WORD_ONE;
  assign cmd_ready  = state_q == H_IDLE;
  assign wr_aligned = align_wr(addr_q, wr_data);

  assign link.ctrl_serial_clock_pin = scl_q;
  assign link.sda_m_o               = 1'b0;
  assign link.sda_m_oe              = drive_q;

  // ----------------------------------------------------------------
  // Quarter-bit timebase and data line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || state_q == H_IDLE) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= tick ? '0 : qcnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sda_sync_q <= 2'h3;
    end else begin
      sda_sync_q <= {sda_sync_q[0], link.ctrl_serial_data_pin};
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q  <= H_IDLE;
      phase_q  <= PH_IDW;
      q_q      <= 2'h0;
      bit_q    <= 4'h0;
      byte_q   <= 3'h0;
      words_q  <= '0;
      addr_q   <= '0;
      xs_q     <= '0;
      read_q   <= 1'b0;
      err_q    <= 1'b0;
      scl_q    <= 1'b1;
      drive_q  <= 1'b0;
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
      done     <= 1'b0;
      nack     <= 1'b0;
    end else begin
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      if (state_q == H_IDLE) begin
        if (cmd_valid) begin
          state_q <= H_START;
          phase_q <= PH_IDW;
          q_q     <= 2'h0;
          bit_q   <= 4'h0;
          byte_q  <= 3'h0;
          read_q  <= cmd_read;
          addr_q  <= cmd_addr;
          words_q <= cmd_words;
          xs_q    <= id_word(RW_WRITE);
          err_q   <= 1'b0;
          nack    <= 1'b0;
        end
      end else if (tick) begin
        q_q <= q_q + 2'h1;
        case (state_q)
          H_START: begin
            case (q_q)
              2'h0: scl_q <= 1'b1;
              2'h1: drive_q <= 1'b1;
              2'h2: scl_q <= 1'b0;
              default: begin
                state_q <= H_BYTE;
                bit_q   <= 4'h0;
              end
            endcase
          end
          H_STOP: begin
            case (q_q)
              2'h0: drive_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: drive_q <= 1'b0;
              default: begin
                state_q <= H_IDLE;
                done    <= 1'b1;
              end
            endcase
          end
          default: begin
            case (q_q)
              2'h0: begin
                if (bit_q == BIT_ACK) begin
                  drive_q <= (phase_q == PH_RD) &&
                             !(last_byte && last_word);
                end else begin
                  drive_q <= (phase_q != PH_RD) && !xs_q[DATA_W-1];
                end
              end
              2'h1: scl_q <= 1'b1;
              2'h2: begin
                if (bit_q != BIT_ACK) begin
                  xs_q <= {xs_q[DATA_W-2:0], sda_sync_q[1]};
                end else if (phase_q != PH_RD) begin
                  err_q <= sda_sync_q[1];
                end
              end
              default: begin
                scl_q <= 1'b0;
                bit_q <= (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
                if (bit_q == BIT_ACK) begin
                  if (err_q) begin
                    state_q <= H_STOP;
                    nack    <= 1'b1;
                  end else begin
                    case (phase_q)
                      PH_IDW: begin
                        phase_q <= PH_ADDR;
                        xs_q    <= addr_q;
                        byte_q  <= 3'h0;
                      end
                      PH_ADDR: begin
                        byte_q <= byte_q + 3'h1;
                        if (byte_q == ADDR_BYTES - 3'h1) begin
                          byte_q <= 3'h0;
                          if (read_q) begin
                            phase_q <= PH_IDR;
                            xs_q    <= id_word(RW_READ);
                            drive_q <= 1'b0;
                            state_q <= H_START;
                          end else begin
                            phase_q <= PH_WR;
                            xs_q    <= wr_aligned;
                            wr_take <= 1'b1;
                          end
                        end
                      end
                      PH_WR: begin
                        byte_q <= byte_q + 3'h1;
                        if (last_byte) begin
                          byte_q  <= 3'h0;
                          addr_q  <= addr_q + 1'b1;
                          words_q <= words_q - 1'b1;
                          if (last_word) begin
                            state_q <= H_STOP;
                          end else begin
                            // Next word may cross into the wide range
                            xs_q    <= align_wr(addr_q + 1'b1, wr_data);
                            wr_take <= 1'b1;
                          end
                        end
                      end
                      PH_IDR: begin
                        phase_q <= PH_RD;
                        byte_q  <= 3'h0;
                      end
                      default: begin
                        byte_q <= byte_q + 3'h1;
                        if (last_byte) begin
                          byte_q   <= 3'h0;
                          addr_q   <= addr_q + 1'b1;
                          words_q  <= words_q - 1'b1;
                          rd_valid <= 1'b1;
                          rd_data  <= is_wide(addr_q) ? xs_q :
                            {{(DATA_W-NARROW_W){1'b0}},
                             xs_q[NARROW_W-1:0]};
                          if (last_word) begin
                            state_q <= H_STOP;
                          end
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        endcase
      end
    end
  end

endmodule : i2c_regacc_host

// File: rtl/i2c_regacc_pkg.sv
package i2c_regacc_pkg;

  // ----------------------------------------------------------------
  // Link identity and field layout
  // ----------------------------------------------------------------
  // Arbitrary 7-bit bus identifier; the direction bit follows it
  localparam logic [6:0]  DEV_ADDR     = 7'h2D;
  localparam logic        RW_READ      = 1'b1;
  localparam logic        RW_WRITE     = 1'b0;
  localparam int          ADDR_W       = 32;
  localparam int          DATA_W       = 32;
  localparam int          NARROW_W     = 16;
  localparam int          BYTE_W       = 8;
  localparam logic [3:0]  BIT_ACK      = 4'h8;
  localparam logic [2:0]  ADDR_BYTES   = 3'h4;
  localparam logic [2:0]  NARROW_BYTES = 3'h2;
  localparam logic [2:0]  WIDE_BYTES   = 3'h4;
  localparam logic [31:0] WIDE_BASE    = 32'h0000_3000;

  // ----------------------------------------------------------------
  // Word size by register address
  // ----------------------------------------------------------------
  function automatic logic is_wide(input logic [ADDR_W-1:0] a);
    return a >= WIDE_BASE;
  endfunction : is_wide

  function automatic logic [2:0] word_bytes(input logic [ADDR_W-1:0] a);
    return is_wide(a) ? WIDE_BYTES : NARROW_BYTES;
  endfunction : word_bytes

endpackage : i2c_regacc_pkg

// File: test/i2c_regacc_asserts.sv
`timescale 1ns/1ps
module i2c_regacc_asserts (
  // Link-domain clock and reset
  input wire logic link_clk,
  input wire logic srst,
  // Link wires
  input wire logic ctrl_serial_clock_pin,
  input wire logic ctrl_serial_data_pin,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  import i2c_regacc_pkg::*;
  logic [3:0] nbit_q;
  logic [7:0] id_q;
  logic       busy_q;
  wire logic  scl = ctrl_serial_clock_pin;
  wire logic  sda = ctrl_serial_data_pin;

  // Bits since the last start; saturates so later bytes are ignored
  always_ff @(posedge link_clk) begin
    if (srst || (scl && $rose(sda))) begin
      nbit_q <= 4'hF;
      busy_q <= 1'b0;
    end else if (scl && $fell(sda)) begin
      nbit_q <= 4'h0;
      busy_q <= 1'b1;
    end else if ($rose(scl) && nbit_q != 4'hF) begin
      nbit_q <= nbit_q + 4'h1;
    end
  end

  always_ff @(posedge link_clk) begin
    if ($rose(scl) && nbit_q < 4'h8) id_q <= {id_q[6:0], sda};
  end

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (srst);

  sequence ack_slot;
    $rose(scl) ##0 nbit_q == 4'h8;
  endsequence
  sequence own_wr_id;
    id_q == {DEV_ADDR, RW_WRITE};
  endsequence

  open_drain_a: assert property (sda_s_oe |-> !sda_s_o)
    else $error("device drives data high");
  pull_up_a: assert property (!sda_s_oe && !sda_m_oe |-> sda)
    else $error("released data line not high");
  id_quiet_a: assert property (nbit_q < 4'h8 |-> !sda_s_oe)
    else $error("device drives during identifier");
  id_ack_a: assert property (ack_slot ##0 own_wr_id |-> !sda)
    else $error("own identifier not acknowledged");
  id_nack_a: assert property (
    ack_slot ##0 id_q[7:1] != DEV_ADDR |-> sda)
    else $error("foreign identifier acknowledged");
  ack_delay_a: assert property (
    $fell(scl) && nbit_q == 4'h8 ##0 own_wr_id |-> ##[1:6] sda_s_oe)
    else $error("acknowledge late");
  // The drive register moved one edge before the change is seen here
  edge_low_a: assert property ($changed(sda_s_oe) |-> !$past(scl))
    else $error("device data changed with clock high");
  drive_hold_a: assert property ($rose(sda_s_oe) |=> sda_s_oe[*8])
    else $error("device drive too short");
  idle_quiet_a: assert property (!busy_q |-> !sda_s_oe)
    else $error("device drives while idle");
endmodule : i2c_regacc_asserts

// File: test/i2c_register_access_slave_test.sv
`timescale 1ns/1ps
module i2c_register_access_slave_test;
  import i2c_regacc_pkg::*;
  typedef struct packed {
    logic        rd;
    logic [31:0] addr;
    logic [7:0]  words;
    logic [31:0] base;
  } row_s;
  // Rows 5 and 6 straddle the word-size boundary
  row_s rows [7] = '{
    '{1'b0, 32'h0000_0010, 8'h01, 32'hCAFE_1234},
    '{1'b1, 32'h0000_0010, 8'h01, 32'h0000_0000},
    '{1'b0, 32'h0000_3000, 8'h03, 32'h1357_9BDF},
    '{1'b1, 32'h0000_3004, 8'h02, 32'h0000_0000},
    '{1'b0, 32'h0000_0020, 8'h03, 32'h0000_FFFE},
    '{1'b1, 32'h0000_2FFF, 8'h02, 32'h0000_0000},
    '{1'b0, 32'h0000_2FFF, 8'h02, 32'hA5A5_7777}};
  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        srst = 1'b1;
  logic        lsrst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_read = 1'b0;
  logic [31:0] cmd_addr = 32'h0000_0000;
  logic [7:0]  cmd_words = 8'h01;
  logic [31:0] wr_data = 32'h0000_0000;
  logic        cmd_ready, wr_take, rd_valid, done, nack, reg_wr, reg_rd;
  logic        f_wr;
  logic [31:0] rd_data, reg_addr, reg_wdata, reg_rdata, f_addr, f_wdata;
  logic [63:0] wq [$];
  logic [63:0] f_last;
  int          f_n = 0;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  ctrl_link_if link ();
  ctrl_link_if spare ();
  i2c_regacc_host #(.SCL_QTR(8), .WORDS_W(8)) i2c_regacc_host_i (
    .clk, .srst, .link(link), .cmd_valid, .cmd_ready, .cmd_read,
    .cmd_addr, .cmd_words, .wr_data, .wr_take, .rd_data, .rd_valid,
    .done, .nack);
  i2c_regacc_device i2c_regacc_device_i (
    .link_clk, .srst(lsrst), .link(link), .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);
  // Second device faces the bench, which breaks the protocol on purpose
  if (1) begin : fault
    i2c_regacc_device i2c_regacc_device_i (
      .link_clk, .srst(lsrst), .link(spare), .reg_addr(f_addr),
      .reg_wdata(f_wdata), .reg_wr(f_wr), .reg_rd(),
      .reg_rdata(32'h0000_0000));
  end
  i2c_regacc_asserts i2c_regacc_asserts_i (
    .link_clk, .srst(lsrst),
    .ctrl_serial_clock_pin(link.ctrl_serial_clock_pin),
    .ctrl_serial_data_pin(link.ctrl_serial_data_pin),
    .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o),
    .sda_s_oe(link.sda_s_oe));

  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0] ^ 16'hA5A5, ~a[15:0]};
  endfunction : pat
  function automatic logic [31:0] msk(input logic [31:0] a);
    return (a >= WIDE_BASE) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
  endfunction : msk
  assign reg_rdata = pat(reg_addr);

  always #12.5 clk = ~clk;
  initial begin
    #7;
    forever #32 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      give_verdict();
    end
  end
  always @(posedge link_clk) begin
    if (reg_wr === 1'b1) wq.push_back({reg_addr, reg_wdata});
    if (f_wr === 1'b1) begin
      f_n++;
      f_last = {f_addr, f_wdata};
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // Both domains are held long enough for the link synchronisers to fill
  task automatic do_reset();
    #1;
    srst = 1'b1;
    lsrst = 1'b1;
    repeat (5) @(posedge link_clk);
    @(posedge clk);
    #1 srst = 1'b0;
    lsrst = 1'b0;
    repeat (20) @(posedge clk);
    #1 chk(64'({cmd_ready, nack, link.sda_s_oe, link.ctrl_serial_data_pin,
               link.ctrl_serial_clock_pin}), 64'h13);
  endtask : do_reset

  task automatic xfer(input row_s r);
    int w;
    int n;
    logic [31:0] a;
    w = 0;
    n = 0;
    wq.delete();
    cmd_valid = 1'b1;
    cmd_read = r.rd;
    cmd_addr = r.addr;
    cmd_words = r.words;
    wr_data = r.base;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    while (done !== 1'b1) begin
      @(posedge clk);
      #1;
      if (wr_take === 1'b1) begin
        w++;
        wr_data = r.base + 32'(w);
      end
      if (rd_valid === 1'b1) begin
        a = r.addr + 32'(n);
        chk(64'(rd_data & msk(a)), 64'(pat(a) & msk(a)));
        n++;
      end
    end
    chk(64'(nack), 64'h0);
    if (r.rd) chk(64'(n), 64'(r.words));
    else begin
      chk(64'(wq.size()), 64'(r.words));
      foreach (wq[i]) begin
        a = r.addr + 32'(i);
        chk(64'(wq[i][63:32]), 64'(a));
        chk(64'(wq[i][31:0]), 64'((r.base + 32'(i)) & msk(a)));
      end
    end
  endtask : xfer

  task automatic bit_out(input logic v);
    spare.ctrl_serial_clock_pin = 1'b0;
    #300 spare.sda_m_oe = !v;
    #300 spare.ctrl_serial_clock_pin = 1'b1;
    #300;
  endtask : bit_out

  task automatic send(input logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_out(1'b1);
    chk(64'(spare.ctrl_serial_data_pin), 64'(!ack));
  endtask : send

  // Start from an idle line, or stop after a low data bit
  task automatic cond(input logic s);
    if (!s) bit_out(1'b0);
    spare.sda_m_oe = s;
    #600;
  endtask : cond

  initial begin
    spare.ctrl_serial_clock_pin = 1'b1;
    spare.sda_m_o = 1'b0;
    spare.sda_m_oe = 1'b0;
    do_reset();
    foreach (rows[i]) xfer(rows[i]);
    cmd_valid = 1'b1;
    cmd_read = 1'b0;
    cmd_addr = 32'h0000_0040;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    repeat (300) @(posedge clk);
    do_reset();
    xfer(rows[0]);
    cond(1'b1);
    send({DEV_ADDR ^ 7'h01, RW_WRITE}, 1'b0);
    cond(1'b0);
    cond(1'b1);
    send({DEV_ADDR, RW_READ}, 1'b0);
    cond(1'b0);
    cond(1'b1);
    send({DEV_ADDR, RW_WRITE}, 1'b1);
    send(8'h00, 1'b1);
    cond(1'b0);
    cond(1'b1);
    send({DEV_ADDR, RW_WRITE}, 1'b1);
    for (int i = 0; i < 6; i++) begin
      send(8'(48'h0000_0040_1234 >> (40 - 8 * i)), 1'b1);
    end
    cond(1'b0);
    chk(64'(f_n), 64'h1);
    chk(f_last, 64'h0000_0040_0000_1234);
    give_verdict();
  end
endmodule : i2c_register_access_slave_test
